// File: verilog/frequency_ramp_generator.sv
// Notes on behaviour
// [RQ1] accel time spans 0 Hz to reference
// [RQ2] decel time spans reference down to 0 Hz
// [RQ3] second-set select picks second time pair
// [RQ4] second decel 9999 reuses second accel
// [RQ5] user maps second-set select to a pin
// [RQ6] S-curve A times refer to base frequency
// [RQ7] S-curve A above base follows quadratic time
// [RQ8] times up to 0.03 s become 0.04 s
// [RQ9] reference change leaves gain frequencies alone
// [RQ10] run starts output at starting frequency
// [RQ11] no start while command below starting frequency
// [RQ12] hold starting frequency for hold time
// [RQ13] run removed in hold starts deceleration
// [RQ14] reversal applies start frequency, skips hold
// [RQ15] start at/below minimum runs preset frequency
// [RQ16] shape select 0 linear, 1 A, 2 B
// [RQ17] linear mode uses constant slope
// [RQ18] S-curve A inflects at base frequency
// [RQ19] S-curve B smooths present to new target
// [RQ20] reference frequency 1 to 400 Hz, 60 default
// [RQ21] ramp times accept 0 to 3600 s
// [RQ22] one clamped step per control tick
//
// Added by the designer: the APB register port and the address map.
`include "ramp_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module frequency_ramp_generator #(
    parameter int TICK_CYCLES = `TICK_CYCLES,
    parameter int TICKS_PER_CS = `TICKS_PER_CS
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [5:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // run terminals and analog command, asynchronous
    input wire ramp_pkg::run_pins_t run_pins,
    input wire logic [15:0] freq_command,
    // drive output
    output ramp_pkg::drive_out_t drive_out
);
    import ramp_pkg::*;

    initial begin
        if (TICK_CYCLES < 64 || TICKS_PER_CS < 1 || TICKS_PER_CS > 1000)
            $error("frequency_ramp_generator: unsupported tick parameters");
    end

    // ****************************************
    // configuration registers
    // ****************************************
    logic [31:0] cfg_r [0:`CFG_COUNT-1];
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic [3:0] idx;
    logic mapped;
    logic setup;
    run_state_t state_r;
    logic [31:0] lin_r;
    logic [31:0] out_r;
    logic dir_r;
    logic [15:0] cmd_s1_r, cmd_s2_r;
    run_pins_t pins_s1_r, pins_s2_r;

    function automatic logic [31:0] rst_val(input int i);
        case (i)
            2: rst_val = `RST_REF_FREQ;
            4, 6: rst_val = `NO_VALUE;
            5: rst_val = `RST_START_FREQ;
            8: rst_val = `RST_BASE_FREQ;
            7, 9, 10, 11, 12: rst_val = `RST_ZERO;
            default: rst_val = `RST_RAMP_TIME;
        endcase
    endfunction : rst_val

    function automatic logic ok_val(input logic [3:0] i, input logic [31:0] d);
        case (i)
            4'd0, 4'd1, 4'd3: ok_val = d <= `MAX_RAMP_TIME; // RQ21
            4'd4: ok_val = d <= `MAX_RAMP_TIME || d == `NO_VALUE;
            4'd2: ok_val = d >= `MIN_REF_FREQ && d <= `MAX_REF_FREQ; // RQ20
            4'd5: ok_val = d <= `MAX_START_FREQ; // RQ10
            4'd6: ok_val = d <= `MAX_HOLD_TIME || d == `NO_VALUE; // RQ12
            4'd7: ok_val = d <= `MAX_SHAPE; // RQ16
            default: ok_val = d <= `MAX_REF_FREQ;
        endcase
    endfunction : ok_val

    assign idx = paddr[5:2];
    assign mapped = paddr[1:0] == 2'b00 && paddr <= `OFS_CMD_READ;
    assign setup = psel && !penable;

    // each register is written alone: the gain pair never follows the reference
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < `CFG_COUNT; i++) cfg_r[i] <= rst_val(i);
        end else if (psel && penable && pready_r && pwrite && !pslverr_r && idx < 4'(`CFG_COUNT)) begin
            cfg_r[idx] <= pwdata; // RQ9
        end
    end

    // zero wait states: answer is ready in the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            pready_r <= setup;
            pslverr_r <= setup && (!mapped || (pwrite && (idx >= 4'(`CFG_COUNT) || !ok_val(idx, pwdata))));
            if (setup && !pwrite && mapped) begin
                if (paddr == `OFS_STATUS)
                    prdata_r <= {12'h000, 2'(state_r), dir_r, state_r != ST_IDLE, out_r[31:16]};
                else if (paddr == `OFS_CMD_READ)
                    prdata_r <= {16'h0000, cmd_s2_r};
                else
                    prdata_r <= cfg_r[idx];
            end else begin
                prdata_r <= 32'h0000_0000;
            end
        end
    end

    // ****************************************
    // input synchronisers
    // ****************************************
    // the command word may tear on a change; it settles within a tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins_s1_r <= '0;
            pins_s2_r <= '0;
            cmd_s1_r <= 16'h0000;
            cmd_s2_r <= 16'h0000;
        end else begin
            pins_s1_r <= run_pins; // RQ5
            pins_s2_r <= pins_s1_r;
            cmd_s1_r <= freq_command;
            cmd_s2_r <= cmd_s1_r;
        end
    end

    // ****************************************
    // run request and effective target
    // ****************************************
    logic run_req, dir_req;
    logic [15:0] start_f, cmd_eff, tgt_f;
    logic [31:0] tgt;
    logic hold_en;
    shape_t shape;

    assign run_req = pins_s2_r.forward_run_command ^ pins_s2_r.reverse_run_command;
    assign dir_req = pins_s2_r.reverse_run_command;
    assign start_f = cfg_r[5][15:0];
    assign shape = shape_t'(cfg_r[7][1:0]); // RQ16
    assign hold_en = cfg_r[6] != `NO_VALUE; // RQ12
    assign cmd_eff = (cfg_r[5] <= cfg_r[9] && cmd_s2_r < start_f) ? cfg_r[10][15:0] : cmd_s2_r; // RQ15
    assign tgt_f = (state_r == ST_RUN && run_req && dir_req == dir_r) ? cmd_eff : 16'h0000; // RQ13
    assign tgt = {tgt_f, 16'h0000};

    // ****************************************
    // slope selection
    // ****************************************
    logic accel;
    logic [31:0] t_sel, t_eff;
    logic [21:0] t_ticks;
    logic [15:0] ref_f, cur_f;
    logic above_base;
    logic [47:0] num, den;

    assign accel = tgt > lin_r;
    always_comb begin
        if (pins_s2_r.second_set_select) begin
            if (accel || cfg_r[4] == `NO_VALUE)
                t_sel = cfg_r[3]; // RQ4
            else
                t_sel = cfg_r[4]; // RQ3
        end else begin
            t_sel = accel ? cfg_r[0] : cfg_r[1]; // RQ1 RQ2
        end
    end
    assign t_eff = (t_sel <= `FAST_LIMIT) ? `FAST_TIME : t_sel; // RQ8
    assign t_ticks = 22'(t_eff * 32'(TICKS_PER_CS));
    assign ref_f = (shape == SHAPE_S_A) ? cfg_r[8][15:0] : cfg_r[2][15:0]; // RQ6
    assign cur_f = lin_r[31:16];
    assign above_base = shape == SHAPE_S_A && cur_f >= cfg_r[8][15:0] && cur_f != 16'h0000; // RQ18

    // above base the slope falls as 9 fb^2 / (8 T f), the derivative of the quadratic time
    always_comb begin
        if (above_base) begin
            num = 48'(9 * 48'(ref_f) * 48'(ref_f)) << 13; // RQ7
            den = 48'(t_ticks) * 48'(cur_f);
        end else begin
            num = {16'h0000, ref_f, 16'h0000}; // RQ17
            den = 48'(t_ticks);
        end
    end

    // ****************************************
    // serial divider, rerun continuously
    // ****************************************
    logic [47:0] div_q_r, div_d_r;
    logic [48:0] div_rem_r, rem_sh;
    logic [5:0] div_cnt_r;
    logic [31:0] step_r;

    // a tick lasts far longer than one division, so the slope is never stale by more than a tick
    assign rem_sh = {div_rem_r[47:0], div_q_r[47]};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q_r <= 48'h0000_0000_0000;
            div_d_r <= 48'h0000_0000_0001;
            div_rem_r <= 49'h0_0000_0000_0000;
            div_cnt_r <= 6'h00;
            step_r <= 32'h0000_0000;
        end else if (div_cnt_r == 6'h00) begin
            step_r <= (div_q_r[47:32] != 16'h0000) ? 32'hFFFF_FFFF : div_q_r[31:0];
            div_q_r <= num;
            div_d_r <= den;
            div_rem_r <= 49'h0_0000_0000_0000;
            div_cnt_r <= 6'd48;
        end else begin
            if (rem_sh >= {1'b0, div_d_r}) begin
                div_rem_r <= rem_sh - {1'b0, div_d_r};
                div_q_r <= {div_q_r[46:0], 1'b1};
            end else begin
                div_rem_r <= rem_sh;
                div_q_r <= {div_q_r[46:0], 1'b0};
            end
            div_cnt_r <= div_cnt_r - 6'd1;
        end
    end

    // ****************************************
    // control tick and start hold timer
    // ****************************************
    logic [31:0] tick_cnt_r;
    logic tick_r;
    logic [21:0] hold_cnt_r;
    logic rev_pend_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_r <= 32'h0000_0000;
            tick_r <= 1'b0;
        end else begin
            tick_r <= tick_cnt_r == 32'(TICK_CYCLES - 1);
            tick_cnt_r <= (tick_cnt_r == 32'(TICK_CYCLES - 1)) ? 32'h0000_0000 : tick_cnt_r + 32'h1;
        end
    end

    // ****************************************
    // run sequencer and ramp
    // ****************************************
    logic start_ok;
    logic [31:0] diff_up, diff_dn, lin_nxt, sm_diff;
    assign start_ok = run_req && cmd_eff >= start_f && cmd_eff != 16'h0000; // RQ11
    assign diff_up = tgt - lin_r;
    assign diff_dn = lin_r - tgt;
    always_comb begin
        if (accel)
            lin_nxt = (diff_up <= step_r) ? tgt : lin_r + step_r; // RQ22
        else
            lin_nxt = (diff_dn <= step_r) ? tgt : lin_r - step_r; // RQ22
    end
    assign sm_diff = (lin_r >= out_r) ? (lin_r - out_r) : (out_r - lin_r);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
            lin_r <= 32'h0000_0000;
            out_r <= 32'h0000_0000;
            dir_r <= 1'b0;
            hold_cnt_r <= 22'h00_0000;
            rev_pend_r <= 1'b0;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    lin_r <= 32'h0000_0000;
                    out_r <= 32'h0000_0000;
                    if (start_ok) begin
                        lin_r <= {start_f, 16'h0000}; // RQ10
                        out_r <= {start_f, 16'h0000};
                        dir_r <= dir_req;
                        hold_cnt_r <= 22'(cfg_r[6] * 32'(TICKS_PER_CS));
                        rev_pend_r <= 1'b0;
                        state_r <= (hold_en && !rev_pend_r) ? ST_HOLD : ST_RUN; // RQ14
                    end
                end
                ST_HOLD: begin
                    if (!run_req || dir_req != dir_r)
                        state_r <= ST_RUN; // RQ13
                    else if (hold_cnt_r == 22'h00_0000)
                        state_r <= ST_RUN; // RQ12
                    else if (tick_r)
                        hold_cnt_r <= hold_cnt_r - 22'h1;
                end
                ST_RUN: begin
                    if (tick_r) begin
                        lin_r <= lin_nxt;
                        if (shape == SHAPE_S_B && sm_diff > 32'h0000_0008) begin
                            if (lin_r >= out_r)
                                out_r <= out_r + (sm_diff >> `SMOOTH_SHIFT); // RQ19
                            else
                                out_r <= out_r - (sm_diff >> `SMOOTH_SHIFT); // RQ19
                        end else begin
                            out_r <= lin_r;
                        end
                    end
                    if (tgt == 32'h0000_0000 && lin_r == 32'h0000_0000 && out_r == 32'h0000_0000) begin
                        state_r <= ST_IDLE;
                        rev_pend_r <= run_req && dir_req != dir_r; // RQ14
                    end
                end
            endcase
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign drive_out = '{freq: out_r[31:16], reverse: dir_r, running: state_r != ST_IDLE};

    // ****************************************
    // assertions
    // ****************************************
    property p_ramp_clamp;
        @(posedge pclk) disable iff (!presetn)
        (state_r == ST_RUN && tick_r && accel) |=> lin_r <= $past(tgt) && lin_r > $past(lin_r);
    endproperty
    a_ramp_clamp: assert property (p_ramp_clamp) else $error("ramp overshoots or stalls rising"); // RQ22

    property p_start_at_start_freq;
        @(posedge pclk) disable iff (!presetn)
        (state_r == ST_IDLE && start_ok) |=> out_r[31:16] == $past(start_f) && state_r != ST_IDLE;
    endproperty
    a_start_at_start_freq: assert property (p_start_at_start_freq) else $error("start not at start frequency"); // RQ10

    property p_no_start_low_cmd;
        @(posedge pclk) disable iff (!presetn)
        (state_r == ST_IDLE && cmd_eff < start_f) |=> state_r == ST_IDLE;
    endproperty
    a_no_start_low_cmd: assert property (p_no_start_low_cmd) else $error("started below start frequency"); // RQ11

    property p_hold_steady;
        @(posedge pclk) disable iff (!presetn)
        (state_r == ST_HOLD) |=> $stable(out_r);
    endproperty
    a_hold_steady: assert property (p_hold_steady) else $error("output moved in start hold"); // RQ12

    property p_hold_abort;
        @(posedge pclk) disable iff (!presetn)
        (state_r == ST_HOLD && !run_req) |=> state_r == ST_RUN ##1 tgt == 32'h0000_0000;
    endproperty
    a_hold_abort: assert property (p_hold_abort) else $error("run removal in hold ignored"); // RQ13

    property p_reverse_skips_hold;
        @(posedge pclk) disable iff (!presetn)
        (state_r == ST_IDLE && start_ok && rev_pend_r) |=> state_r == ST_RUN;
    endproperty
    a_reverse_skips_hold: assert property (p_reverse_skips_hold) else $error("hold applied on reversal"); // RQ14

    property p_fast_time;
        @(posedge pclk) disable iff (!presetn)
        (t_sel <= `FAST_LIMIT) |-> t_eff == `FAST_TIME;
    endproperty
    a_fast_time: assert property (p_fast_time) else $error("short ramp time not raised"); // RQ8

    property p_second_decel;
        @(posedge pclk) disable iff (!presetn)
        (pins_s2_r.second_set_select && cfg_r[4] == `NO_VALUE) |-> t_sel == cfg_r[3];
    endproperty
    a_second_decel: assert property (p_second_decel) else $error("second decel sentinel not honoured"); // RQ4

    property p_gain_kept;
        @(posedge pclk) disable iff (!presetn)
        $changed(cfg_r[2]) |-> $stable(cfg_r[11]) && $stable(cfg_r[12]);
    endproperty
    a_gain_kept: assert property (p_gain_kept) else $error("gain changed with reference"); // RQ9
endmodule : frequency_ramp_generator
`default_nettype wire

// File: verilog/ramp_consts.svh
`ifndef RAMP_CONSTS_SVH
`define RAMP_CONSTS_SVH
// ****************************************
// register byte offsets
// ****************************************
`define OFS_ACCEL_TIME 6'h00
`define OFS_DECEL_TIME 6'h04
`define OFS_REF_FREQ 6'h08
`define OFS_SECOND_RAMP 6'h0C
`define OFS_SECOND_DECEL 6'h10
`define OFS_START_FREQ 6'h14
`define OFS_START_HOLD 6'h18
`define OFS_RAMP_SHAPE 6'h1C
`define OFS_BASE_FREQ 6'h20
`define OFS_MIN_FREQ 6'h24
`define OFS_PRESET_FREQ 6'h28
`define OFS_GAIN1_FREQ 6'h2C
`define OFS_GAIN2_FREQ 6'h30
`define OFS_STATUS 6'h34
`define OFS_CMD_READ 6'h38
`define CFG_COUNT 13
// ****************************************
// reset values, limits (time 0.01 s, freq 0.01 Hz)
// ****************************************
`define RST_RAMP_TIME 32'h0000_01F4
`define RST_REF_FREQ 32'h0000_1770
`define RST_START_FREQ 32'h0000_0032
`define RST_BASE_FREQ 32'h0000_1770
`define RST_ZERO 32'h0000_0000
`define NO_VALUE 32'h000F_41DC
`define MAX_RAMP_TIME 32'h0005_7E40
`define MAX_HOLD_TIME 32'h0000_03E8
`define MIN_REF_FREQ 32'h0000_0064
`define MAX_REF_FREQ 32'h0000_9C40
`define MAX_START_FREQ 32'h0000_1770
`define MAX_SHAPE 32'h0000_0002
`define FAST_LIMIT 32'h0000_0003
`define FAST_TIME 32'h0000_0004
// ****************************************
// timing
// ****************************************
`define CLK_MHZ 200
`define TICK_US 1000
`define TICK_CYCLES (`TICK_US * `CLK_MHZ)
`define TICKS_PER_CS (10000 / `TICK_US)
`define SMOOTH_SHIFT 3
`endif

// File: verilog/ramp_pkg.sv
package ramp_pkg;
    typedef enum logic [1:0] {SHAPE_LINEAR, SHAPE_S_A, SHAPE_S_B} shape_t;
    typedef enum {ST_IDLE, ST_HOLD, ST_RUN} run_state_t;
    typedef struct packed {
        logic forward_run_command;
        logic reverse_run_command;
        logic second_set_select;
    } run_pins_t;
    typedef struct packed {
        logic [15:0] freq;
        logic reverse;
        logic running;
    } drive_out_t;
endpackage : ramp_pkg

// File: dv/drive_terminal_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// terminal block and motor stage
// ****************************************
module drive_terminal_model #(
    parameter int SECOND_FUNC = 3
) (
    // clock
    input wire logic pclk,
    // levels asked for by the bench
    input wire logic [2:0] pin_lvl,
    input wire logic [2:0] pin4_func,
    input wire logic [15:0] cmd_lvl,
    // drive side
    input wire ramp_pkg::drive_out_t drive_out,
    output var ramp_pkg::run_pins_t run_pins,
    output logic [15:0] freq_command,
    output int motor_speed
);
    import ramp_pkg::*;
    initial begin
        run_pins = '0;
        freq_command = '0;
        motor_speed = 0;
    end
    // terminals move just after the edge, like contacts seen through a filter
    always @(posedge pclk) begin
        run_pins.forward_run_command <= pin_lvl[0];
        run_pins.reverse_run_command <= pin_lvl[1];
        // second set only when the spare pin carries that function code
        run_pins.second_set_select <= pin_lvl[2] && (pin4_func == SECOND_FUNC[2:0]);
        freq_command <= cmd_lvl;
        motor_speed <= drive_out.running ? int'(drive_out.freq) : 0;
    end
endmodule : drive_terminal_model
`default_nettype wire

// File: dv/frequency_ramp_generator_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "ramp_consts.svh"
`define CHK(g, e) check_val(32'(g), 32'(e))
module frequency_ramp_generator_bench;
    import ramp_pkg::*;
    // ****************************************
    // signals
    // ****************************************
    localparam int TK = 100;
    localparam logic [5:0] OFS [10] = '{`OFS_ACCEL_TIME, `OFS_DECEL_TIME, `OFS_REF_FREQ, `OFS_SECOND_RAMP,
        `OFS_SECOND_DECEL, `OFS_START_FREQ, `OFS_START_HOLD, `OFS_RAMP_SHAPE, `OFS_BASE_FREQ, `OFS_MIN_FREQ};
    localparam logic [31:0] RSTV [10] = '{`RST_RAMP_TIME, `RST_RAMP_TIME, `RST_REF_FREQ, `RST_RAMP_TIME,
        `NO_VALUE, `RST_START_FREQ, `NO_VALUE, `RST_ZERO, `RST_BASE_FREQ, `RST_ZERO};
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [5:0] paddr = 6'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [2:0] pin_lvl = 3'h0;
    logic [2:0] pin4_func = 3'h3;
    logic [15:0] cmd_lvl = 16'h0;
    run_pins_t run_pins;
    logic [15:0] freq_command;
    drive_out_t drive_out;
    int motor_speed;
    int bad_count = 0;
    int checks_done = 0;
    int cycles = 0;
    int exp_f = 0;
    int first_n;
    int tgt;
    logic [31:0] rd;
    logic err;
    always #2.5 pclk = ~pclk;
    frequency_ramp_generator #(.TICK_CYCLES(TK), .TICKS_PER_CS(1)) uut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .run_pins(run_pins), .freq_command(freq_command),
        .drive_out(drive_out));
    drive_terminal_model term (.pclk(pclk), .pin_lvl(pin_lvl), .pin4_func(pin4_func), .cmd_lvl(cmd_lvl),
        .drive_out(drive_out), .run_pins(run_pins), .freq_command(freq_command), .motor_speed(motor_speed));
    // ****************************************
    // tasks
    // ****************************************
    task automatic check_val(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : check_val
    task automatic give_verdict;
        $display("checks=%0d mismatches=%0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict
    // request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [5:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wreg(input logic [5:0] a, input logic [31:0] d, input logic e);
        apb(1'b1, a, d);
        `CHK(err, e);
    endtask : wreg
    task automatic wait_run(input logic rev);
        int n;
        n = 0;
        while (!(drive_out.running === 1'b1 && drive_out.reverse === rev) && n < 40 * TK) begin
            @(posedge pclk);
            n++;
        end
    endtask : wait_run
    // integer model of the ramp: one clamped step per output change
    task automatic follow(input int t, input int step);
        int n;
        n = 0;
        first_n = -1;
        while (exp_f != t && n < 40 * TK) begin
            @(posedge pclk);
            n++;
            if (drive_out.freq !== 16'(exp_f)) begin
                if (first_n < 0)
                    first_n = n;
                exp_f = (t > exp_f) ? ((exp_f + step > t) ? t : exp_f + step)
                    : ((exp_f - step < t) ? t : exp_f - step);
                `CHK(drive_out.freq, exp_f);
            end
        end
    endtask : follow
    task automatic start_run(input logic [2:0] pins);
        pin_lvl <= pins;
        wait_run(pins[1]);
        `CHK(drive_out.freq, 16'h01F4);
        exp_f = 500;
    endtask : start_run
    task automatic idle_wait;
        repeat (3 * TK) @(posedge pclk);
        `CHK(drive_out.running, 1'b0);
    endtask : idle_wait
    // ****************************************
    // hang guard and main sequence
    // ****************************************
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            bad_count++;
            give_verdict();
        end
    end
    initial begin
        void'($urandom(17));
        tgt = 3000 + int'($urandom % 3000);
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        foreach (OFS[i]) begin
            apb(1'b0, OFS[i], 32'h0);
            `CHK(rd, RSTV[i]);
        end
        apb(1'b0, 6'h3C, 32'h0);
        `CHK(err, 1'b1);
        wreg(`OFS_REF_FREQ, 32'h0000_9C41, 1'b1);
        wreg(`OFS_REF_FREQ, 32'h0000_0063, 1'b1);
        wreg(`OFS_ACCEL_TIME, 32'h0005_7E41, 1'b1);
        wreg(`OFS_RAMP_SHAPE, 32'h0000_0003, 1'b1);
        wreg(`OFS_GAIN1_FREQ, 32'h0000_04D2, 1'b0);
        wreg(`OFS_REF_FREQ, 32'h0000_2EE0, 1'b0);
        apb(1'b0, `OFS_GAIN1_FREQ, 32'h0);
        `CHK(rd, 32'h0000_04D2);
        wreg(`OFS_REF_FREQ, 32'h0000_1770, 1'b0);
        wreg(`OFS_ACCEL_TIME, 32'h0000_000A, 1'b0);
        wreg(`OFS_DECEL_TIME, 32'h0000_0014, 1'b0);
        wreg(`OFS_START_FREQ, 32'h0000_01F4, 1'b0);
        wreg(`OFS_START_HOLD, 32'h0000_0005, 1'b0);
        // command below the starting frequency must not start the drive
        cmd_lvl <= 16'h0190;
        pin_lvl <= 3'h1;
        repeat (3 * TK) @(posedge pclk);
        `CHK(drive_out.running, 1'b0);
        cmd_lvl <= 16'(tgt);
        start_run(3'h1);
        follow(tgt, 600);
        `CHK(first_n >= 4 * TK && first_n <= 7 * TK, 1'b1);
        pin_lvl <= 3'h0;
        follow(0, 300);
        idle_wait();
        // run dropped in mid-hold: the fall begins at once
        start_run(3'h1);
        repeat (2 * TK) @(posedge pclk);
        pin_lvl <= 3'h0;
        follow(0, 300);
        `CHK(first_n <= 2 * TK, 1'b1);
        idle_wait();
        wreg(`OFS_START_HOLD, `NO_VALUE, 1'b0);
        wreg(`OFS_SECOND_RAMP, 32'h0000_0005, 1'b0);
        repeat (2 * TK) @(posedge pclk);
        start_run(3'h5);
        follow(tgt, 1200);
        pin_lvl <= 3'h4;
        follow(0, 1200);
        idle_wait();
        wreg(`OFS_ACCEL_TIME, 32'h0000_0003, 1'b0);
        wreg(`OFS_START_HOLD, 32'h0000_0005, 1'b0);
        repeat (2 * TK) @(posedge pclk);
        start_run(3'h1);
        follow(tgt, 1500);
        pin_lvl <= 3'h2;
        follow(0, 300);
        start_run(3'h2);
        follow(tgt, 1500);
        `CHK(first_n <= 2 * TK, 1'b1);
        pin_lvl <= 3'h0;
        follow(0, 300);
        idle_wait();
        // preset frequency runs with no command when start is at or below minimum
        wreg(`OFS_MIN_FREQ, 32'h0000_01F4, 1'b0);
        wreg(`OFS_PRESET_FREQ, 32'h0000_07D0, 1'b0);
        wreg(`OFS_ACCEL_TIME, 32'h0000_000A, 1'b0);
        cmd_lvl <= 16'h0;
        repeat (2 * TK) @(posedge pclk);
        start_run(3'h1);
        follow(2000, 600);
        pin_lvl <= 3'h0;
        follow(0, 300);
        idle_wait();
        // mode A below base: time refers to base, so base 120 Hz doubles the slope
        wreg(`OFS_MIN_FREQ, 32'h0, 1'b0);
        wreg(`OFS_BASE_FREQ, 32'h0000_2EE0, 1'b0);
        wreg(`OFS_RAMP_SHAPE, 32'h0000_0001, 1'b0);
        cmd_lvl <= 16'(tgt);
        repeat (2 * TK) @(posedge pclk);
        start_run(3'h1);
        follow(tgt, 1200);
        pin_lvl <= 3'h0;
        follow(0, 600);
        idle_wait();
        // mode B closes 1/8 of the gap per tick and snaps to the target within 8 LSBs; the last fraction of a step is allowed
        wreg(`OFS_RAMP_SHAPE, 32'h0000_0002, 1'b0);
        repeat (2 * TK) @(posedge pclk);
        start_run(3'h1);
        repeat (150 * TK) @(posedge pclk);
        `CHK(int'(drive_out.freq) > tgt - 8 && int'(drive_out.freq) <= tgt, 1'b1);
        `CHK(motor_speed, drive_out.freq);
        // status: run state, forward, running, output frequency in the low half
        apb(1'b0, `OFS_STATUS, 32'h0);
        `CHK(rd, 32'h0009_0000 | 32'(drive_out.freq));
        apb(1'b0, `OFS_CMD_READ, 32'h0);
        `CHK(rd, tgt);
        wreg(`OFS_STATUS, 32'h0000_0000, 1'b1);
        give_verdict();
    end
endmodule : frequency_ramp_generator_bench
`default_nettype wire
